// ### rtl/dual_digipot_command_decoder.sv
// command decoder and register logic of a two-channel digital potentiometer
`include "digipot_cfg.svh"
module dual_digipot_command_decoder
  import digipot_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire cmd_word_t cmd_word,
  input wire logic burst_valid,
  input wire logic [7:0] burst_byte,
  input wire logic frame_start,
  input wire logic independent_mode_pin,
  input wire logic reset_pin_n,
  output logic read_valid,
  output logic [7:0] read_data,
  output logic busy,
  output logic [3:0] control_bits,
  output string_drive_t channel_drive [2]
);
  localparam int NREG = 4;
  localparam logic [W-1:0] MAXC = {W{1'b1}};
  localparam logic [W-1:0] MIDC = W'(1) << (W - 1);
  localparam logic [9:0] RELOAD_LAST = 10'(`RELOAD_CYCLES - 1);

  // register index is {channel, string}; true when the address reaches it
  function automatic logic hits(input logic [3:0] addr, input int idx);
    return addr[`ADDR_ALL] ||
      (addr[`ADDR_CHAN] == idx[1] && addr[`ADDR_STRING] == idx[0]);
  endfunction

  function automatic logic chan_hit(input logic [3:0] addr, input int ch);
    return addr[`ADDR_ALL] || (addr[`ADDR_CHAN] == ch[0]);
  endfunction

  logic [W-1:0] wiper_setting_reg [NREG];
  logic [W-1:0] input_reg [NREG], nv_reg [NREG];
  logic [W-1:0] wiper_next [NREG], input_next [NREG];
  logic [NREG-1:0] wiper_we;
  logic [3:0] ctrl_reg, cmd_hold_op_reg, cmd_hold_addr_reg;
  logic [1:0] upper_end_position_reg, lower_end_position_reg, shutdown_reg;
  ctl_state_t state_reg;
  logic [9:0] reload_cnt_reg;
  logic rst_pin_meta, rst_pin_sync, rst_pin_prev, independent_mode_pin_meta, independent_mode_pin_sync;
  logic burst_armed_reg, reload_done, burst_ok, exec_valid, d0;
  cmd_word_t exec_word;
  logic [W-1:0] data_w;
  logic wiper_en, nv_en, linear_mode, load_wiper_strobe;
  string_drive_t drive_comb [2];

  // two-flop synchronisers for the pins
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rst_pin_meta <= 1'b1;
      rst_pin_sync <= 1'b1;
      rst_pin_prev <= 1'b1;
      independent_mode_pin_meta <= 1'b0;
      independent_mode_pin_sync <= 1'b0;
    end else begin
      rst_pin_meta <= reset_pin_n;
      rst_pin_sync <= rst_pin_meta;
      rst_pin_prev <= rst_pin_sync;
      independent_mode_pin_meta <= independent_mode_pin;
      independent_mode_pin_sync <= independent_mode_pin_meta;
    end
  end

  // burst: remember command byte until the next start condition
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_hold_op_reg <= `OP_NOP;
      cmd_hold_addr_reg <= 4'h0;
      burst_armed_reg <= 1'b0;
    end else if (cmd_valid) begin
      cmd_hold_op_reg <= cmd_word.op;
      cmd_hold_addr_reg <= cmd_word.addr;
      burst_armed_reg <= 1'b1;
    end else if (frame_start) begin
      burst_armed_reg <= 1'b0;
    end
  end

  // pick the word to execute; a full word wins over a burst byte
  assign burst_ok = burst_valid && burst_armed_reg && ctrl_reg[`CTRL_BURST];
  assign exec_valid = (state_reg == ST_RUN) && (cmd_valid || burst_ok);
  assign exec_word = cmd_valid ? cmd_word : {cmd_hold_op_reg, cmd_hold_addr_reg, burst_byte};
  assign data_w = exec_word.data[W-1:0];
  assign d0 = exec_word.data[`DATA_D0];
  assign wiper_en = ctrl_reg[`CTRL_WIPER_EN];
  assign nv_en = ctrl_reg[`CTRL_NV_EN];
  assign linear_mode = independent_mode_pin_sync | ctrl_reg[`CTRL_LINEAR];
  assign load_wiper_strobe = exec_valid && exec_word.op == `OP_LOAD;

  // reload sequencer: after reset, reset command or low pin pulse
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= ST_RELOAD;
      reload_cnt_reg <= 10'h000;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          reload_cnt_reg <= 10'h000;
          if ((exec_valid && exec_word.op == `OP_SW_RESET) ||
              (rst_pin_prev && !rst_pin_sync)) begin
            state_reg <= ST_RELOAD;
          end
        end
        ST_RELOAD: begin
          reload_cnt_reg <= reload_cnt_reg + 10'h001;
          if (reload_done) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end
  assign reload_done = (state_reg == ST_RELOAD) && (reload_cnt_reg == RELOAD_LAST);

  // next wiper and input values per register
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      wiper_next[i] = wiper_setting_reg[i];
      input_next[i] = input_reg[i];
      wiper_we[i] = 1'b0;
      if (exec_valid && hits(exec_word.addr, i)) begin
        case (exec_word.op)
          `OP_WR_WIPER: begin
            wiper_next[i] = data_w;
            wiper_we[i] = wiper_en;
          end
          `OP_WR_INPUT: input_next[i] = data_w;
          `OP_STEP: begin
            if (d0) begin
              wiper_next[i] = (wiper_setting_reg[i] == MAXC) ? MAXC
                : wiper_setting_reg[i] + W'(1);
            end else begin
              wiper_next[i] = (wiper_setting_reg[i] == '0) ? '0
                : wiper_setting_reg[i] - W'(1);
            end
            wiper_we[i] = wiper_en;
          end
          `OP_SHIFT: begin
            if (!d0) begin
              wiper_next[i] = wiper_setting_reg[i] >> 1;
            end else if (wiper_setting_reg[i] == '0) begin
              wiper_next[i] = W'(1);
            end else if (wiper_setting_reg[i][W-1]) begin
              wiper_next[i] = MAXC;
            end else begin
              wiper_next[i] = wiper_setting_reg[i] << 1;
            end
            wiper_we[i] = wiper_en;
          end
          `OP_LOAD: begin
            wiper_next[i] = input_reg[i];
            wiper_we[i] = wiper_en && load_wiper_strobe;
          end
          `OP_NV_XFER: begin
            wiper_next[i] = nv_reg[i];
            wiper_we[i] = !d0;
          end
          default: ;
        endcase
      end
      if (wiper_we[i]) begin
        input_next[i] = wiper_next[i];
      end
    end
  end

  // wiper and input registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < NREG; i++) begin
        wiper_setting_reg[i] <= MIDC;
        input_reg[i] <= MIDC;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        if (reload_done) begin
          wiper_setting_reg[i] <= nv_reg[i];
          input_reg[i] <= nv_reg[i];
        end else begin
          if (wiper_we[i]) begin
            wiper_setting_reg[i] <= wiper_next[i];
          end
          input_reg[i] <= input_next[i];
        end
      end
    end
  end

  // nonvolatile copies, stores gated by control bit 1
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < NREG; i++) begin
        nv_reg[i] <= MIDC;
      end
    end else if (exec_valid && nv_en) begin
      for (int i = 0; i < NREG; i++) begin
        if (exec_word.op == `OP_NV_XFER && d0 && hits(exec_word.addr, i)) begin
          nv_reg[i] <= wiper_setting_reg[i];
        end else if (exec_word.op == `OP_WR_NV && exec_word.addr[1:0] == 2'(i)) begin
          nv_reg[i] <= data_w;
        end
      end
    end
  end

  // control register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (exec_valid && exec_word.op == `OP_WR_CTRL) begin
      ctrl_reg <= exec_word.data[3:0];
    end
  end

  // end positions and shutdown per channel
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      upper_end_position_reg <= 2'h0;
      lower_end_position_reg <= 2'h0;
      shutdown_reg <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (exec_valid && chan_hit(exec_word.addr, c) && exec_word.op == `OP_SCALE) begin
          if (exec_word.data[`SCALE_TOP_BIT]) begin
            upper_end_position_reg[c] <= d0;
          end else begin
            lower_end_position_reg[c] <= d0;
          end
        end else if (exec_valid && chan_hit(exec_word.addr, c) &&
                     exec_word.op == `OP_SHUTDOWN) begin
          shutdown_reg[c] <= d0;
          if (d0) begin
            upper_end_position_reg[c] <= 1'b0;
            lower_end_position_reg[c] <= 1'b0;
          end
        end else if (wiper_we[2*c] || wiper_we[2*c+1] || reload_done) begin
          upper_end_position_reg[c] <= 1'b0; // new data leaves end positions
          lower_end_position_reg[c] <= 1'b0;
        end
      end
    end
  end

  // readback of input, nonvolatile, control or wiper
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      read_valid <= 1'b0;
      read_data <= 8'h00;
    end else begin
      read_valid <= exec_valid && exec_word.op == `OP_READ;
      if (exec_valid && exec_word.op == `OP_READ) begin
        unique case (exec_word.data[1:0])
          `RD_INPUT: read_data <= 8'(input_reg[{exec_word.addr[0], exec_word.addr[2]}]);
          `RD_NV: read_data <= 8'(nv_reg[exec_word.addr[1:0]]);
          `RD_CTRL: read_data <= {4'h0, ctrl_reg};
          `RD_WIPER: read_data <= 8'(wiper_setting_reg[{exec_word.addr[0], exec_word.addr[2]}]);
        endcase
      end
    end
  end

  // tap decoding per channel, registered onto the outputs
  for (genvar c = 0; c < 2; c++) begin : g_chan
    tap_select_decoder #(.W(W)) u_dec (
      .mclk(mclk),
      .rstn(rstn),
      .lower_code(wiper_setting_reg[2*c]),
      .upper_code(wiper_setting_reg[2*c+1]),
      .linear_mode(linear_mode),
      .upper_end(upper_end_position_reg[c]),
      .lower_end(lower_end_position_reg[c]),
      .shutdown(shutdown_reg[c]),
      .drive(drive_comb[c])
    );
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        channel_drive[c] <= '0;
      end else begin
        channel_drive[c] <= drive_comb[c];
      end
    end
  end

  // status outputs
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busy <= 1'b1;
      control_bits <= `CTRL_RESET;
    end else begin
      busy <= (state_reg == ST_RELOAD) && !reload_done;
      control_bits <= ctrl_reg;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sw_reset_start_a: assert property (exec_valid && exec_word.op == `OP_SW_RESET
    |=> state_reg == ST_RELOAD ##1 busy)
    else $error("reset command did not start a reload");
  reload_finish_a: assert property (reload_done
    |=> state_reg == ST_RUN && wiper_setting_reg[0] == $past(nv_reg[0]))
    else $error("reload did not restore wiper");
  ctrl_write_a: assert property (exec_valid && exec_word.op == `OP_WR_CTRL
    |=> ##1 control_bits == $past(exec_word.data[3:0], 2))
    else $error("control register not loaded");
  wiper_write_a: assert property (exec_valid && exec_word.op == `OP_WR_WIPER &&
    exec_word.addr == 4'h0 && wiper_en |=> wiper_setting_reg[0] == $past(data_w))
    else $error("wiper write lost");
  wiper_freeze_a: assert property (!wiper_en && !reload_done &&
    !(exec_valid && exec_word.op == `OP_NV_XFER) |=> $stable(wiper_setting_reg[0]))
    else $error("protected wiper changed");
  nv_block_a: assert property (!nv_en |=> $stable(nv_reg[0]) && $stable(nv_reg[3]))
    else $error("nonvolatile store while disabled");
  step_sat_a: assert property (exec_valid && exec_word.op == `OP_STEP && d0 &&
    exec_word.addr == 4'h0 && wiper_en && wiper_setting_reg[0] == MAXC
    |=> wiper_setting_reg[0] == MAXC)
    else $error("increment passed full scale");
  readback_a: assert property (exec_valid && exec_word.op == `OP_READ &&
    exec_word.data[1:0] == `RD_CTRL |=> read_valid && read_data == {4'h0, $past(ctrl_reg)})
    else $error("control readback wrong");
  burst_apply_a: assert property (exec_valid && !cmd_valid && wiper_en &&
    cmd_hold_op_reg == `OP_WR_WIPER && cmd_hold_addr_reg == 4'h0
    |=> wiper_setting_reg[0] == $past(burst_byte[W-1:0]))
    else $error("burst byte not applied");
  reload_c: cover property (reload_done);
  burst_c: cover property (burst_ok && !cmd_valid && exec_valid);
  top_end_c: cover property (upper_end_position_reg[0] ##1 !upper_end_position_reg[0]);
  read_c: cover property (read_valid);
endmodule // dual_digipot_command_decoder

// ### rtl/digipot_cfg.svh
// constants of the two-channel potentiometer command decoder
`ifndef DIGIPOT_CFG_SVH
`define DIGIPOT_CFG_SVH

// command field codes
`define OP_NOP 4'h0
`define OP_WR_WIPER 4'h1
`define OP_WR_INPUT 4'h2
`define OP_READ 4'h3
`define OP_STEP 4'h4
`define OP_SHIFT 4'h5
`define OP_LOAD 4'h6
`define OP_NV_XFER 4'h7
`define OP_WR_NV 4'h8
`define OP_SCALE 4'h9
`define OP_SW_RESET 4'hB
`define OP_SHUTDOWN 4'hC
`define OP_WR_CTRL 4'hD

// address field bit positions
`define ADDR_ALL 3
`define ADDR_STRING 2
`define ADDR_CHAN 0

// data field positions
`define DATA_D0 0
`define SCALE_TOP_BIT 7

// control register bits and reset value
`define CTRL_WIPER_EN 0
`define CTRL_NV_EN 1
`define CTRL_LINEAR 2
`define CTRL_BURST 3
`define CTRL_RESET 4'h3

// readback selectors
`define RD_INPUT 2'h0
`define RD_NV 2'h1
`define RD_CTRL 2'h2
`define RD_WIPER 2'h3

// tap count width, enough for 256 taps plus one
`define TAP_W 9

// reload time from nonvolatile memory
`define RELOAD_NS 30000
`define MCLK_MHZ 20
`define RELOAD_CYCLES ((`RELOAD_NS * `MCLK_MHZ + 999) / 1000)

`endif

// ### rtl/digipot_pkg.sv
// types shared by the potentiometer command decoder
`include "digipot_cfg.svh"
package digipot_pkg;
  // one received serial word
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] addr;
    logic [7:0] data;
  } cmd_word_t;

  // drive of one channel's two resistor strings
  typedef struct packed {
    logic [`TAP_W-1:0] upper_string_resistance;
    logic [`TAP_W-1:0] lower_string_resistance;
    logic upper_open;
    logic lower_open;
  } string_drive_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RELOAD = 2'b10
  } ctl_state_t;
endpackage

// ### rtl/tap_select_decoder.sv
// wiper code to resistor-string tap selection for one channel
`include "digipot_cfg.svh"
module tap_select_decoder
  import digipot_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] lower_code,
  input wire logic [W-1:0] upper_code,
  input wire logic linear_mode,
  input wire logic upper_end,
  input wire logic lower_end,
  input wire logic shutdown,
  output string_drive_t drive
);
  localparam logic [`TAP_W-1:0] FULL = `TAP_W'(1) << W;
  localparam logic [`TAP_W-1:0] ZERO = `TAP_W'(0);

  // pick taps by mode, end positions and shutdown
  always_comb begin
    drive.upper_open = 1'b0;
    drive.lower_open = 1'b0;
    drive.lower_string_resistance = `TAP_W'(lower_code);
    if (linear_mode) begin
      drive.upper_string_resistance = `TAP_W'(upper_code);
    end else begin
      drive.upper_string_resistance = FULL - `TAP_W'(lower_code);
    end
    if (shutdown) begin
      drive.upper_open = 1'b1;
      drive.lower_open = linear_mode;
      drive.lower_string_resistance = ZERO;
      drive.upper_string_resistance = ZERO;
    end else if (upper_end) begin
      drive.upper_string_resistance = linear_mode ? FULL : ZERO;
      drive.lower_string_resistance = FULL;
    end else if (lower_end) begin
      drive.upper_string_resistance = linear_mode ? ZERO : FULL;
      drive.lower_string_resistance = ZERO;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  pot_complement_a: assert property (!linear_mode && !shutdown && !upper_end && !lower_end
    |-> drive.upper_string_resistance + drive.lower_string_resistance == FULL)
    else $error("upper string is not the complement of lower");
  linear_upper_a: assert property (linear_mode && !shutdown && !upper_end && !lower_end
    |-> drive.upper_string_resistance == `TAP_W'(upper_code))
    else $error("linear mode upper string ignores its code");
  top_scale_a: assert property (!linear_mode && !shutdown && upper_end
    |-> drive.upper_string_resistance == ZERO && drive.lower_string_resistance == FULL)
    else $error("top scale taps wrong");
endmodule // tap_select_decoder

// ### verif/host_model.sv
// host side model that sends command words, burst bytes and frame starts
module host_model
  import digipot_pkg::*;
(
  input wire logic mclk,
  input wire logic busy,
  input wire logic read_valid,
  input wire logic [7:0] read_data,
  output logic cmd_valid,
  output cmd_word_t cmd_word,
  output logic burst_valid,
  output logic [7:0] burst_byte,
  output logic frame_start
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    burst_valid = 1'b0;
    burst_byte = 8'h00;
    frame_start = 1'b0;
  end

  // waits until the block is idle, then holds one word across one edge
  task automatic send(input logic [15:0] w, output bit ok);
    int n;
    n = 0;
    @(negedge mclk);
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    ok = (n < 1000);
    cmd_valid = 1'b1;
    cmd_word = w;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_word = ~w; // released word shows no stale value
  endtask

  // one extra data byte after the command word of the same frame
  task automatic burst(input logic [7:0] b);
    burst_valid = 1'b1;
    burst_byte = b;
    @(negedge mclk);
    burst_valid = 1'b0;
    burst_byte = ~b;
  endtask

  // start or repeated start seen on the link
  task automatic frame();
    frame_start = 1'b1;
    @(negedge mclk);
    frame_start = 1'b0;
  endtask

  // sends a readback word and takes the answer on its one-cycle pulse
  task automatic rd(input logic [15:0] w, output logic [7:0] d, output bit ok);
    int n;
    send(w, ok);
    n = 0;
    while (read_valid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    ok = ok && (n < 4);
    d = read_data;
  endtask
endmodule // host_model

// ### verif/dual_digipot_command_decoder_tb.sv
// self-checking bench of the two-channel potentiometer command decoder
module dual_digipot_command_decoder_tb
  import digipot_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] rq;
    logic [7:0] exp;
  } row_t;

  logic mclk, rstn, cmd_valid, burst_valid, frame_start, independent_mode_pin, reset_pin_n;
  logic read_valid, busy;
  cmd_word_t cmd_word;
  logic [7:0] burst_byte, read_data, d;
  logic [3:0] control_bits;
  string_drive_t channel_drive [2];
  int err_count, n_checks, n;
  bit ok;
  // command, readback word, expected answer
  row_t rows [29] = '{
    {16'h0000, 16'h3003, 8'h80}, {16'h1040, 16'h3003, 8'h40}, {16'h2055, 16'h3000, 8'h55},
    {16'h6000, 16'h3003, 8'h55}, {16'h4001, 16'h3003, 8'h56}, {16'h4000, 16'h3003, 8'h55},
    {16'h5001, 16'h3003, 8'hAA}, {16'h5001, 16'h3003, 8'hFF}, {16'h4001, 16'h3003, 8'hFF},
    {16'h5000, 16'h3003, 8'h7F},
    {16'h7001, 16'h3001, 8'h7F}, {16'h1010, 16'h3003, 8'h10}, {16'h7000, 16'h3003, 8'h7F},
    {16'hD002, 16'h3002, 8'h02}, {16'h1020, 16'h3003, 8'h7F}, {16'h4001, 16'h3003, 8'h7F},
    {16'hD001, 16'h3002, 8'h01}, {16'h1030, 16'h3003, 8'h30}, {16'h7001, 16'h3001, 8'h7F},
    {16'hD002, 16'h3002, 8'h02}, {16'h7000, 16'h3003, 8'h7F}, {16'hD003, 16'h3002, 8'h03},
    {16'h1811, 16'h3103, 8'h11}, {16'h4801, 16'h3503, 8'h12}, {16'h8222, 16'h3201, 8'h22},
    {16'h1801, 16'h3003, 8'h01}, {16'h5000, 16'h3003, 8'h00}, {16'h4000, 16'h3003, 8'h00},
    {16'h5001, 16'h3003, 8'h01}
  };

  dual_digipot_command_decoder #(.W(8)) dual_digipot_command_decoder_i (
    .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .burst_valid(burst_valid), .burst_byte(burst_byte), .frame_start(frame_start),
    .independent_mode_pin(independent_mode_pin), .reset_pin_n(reset_pin_n),
    .read_valid(read_valid), .read_data(read_data), .busy(busy),
    .control_bits(control_bits), .channel_drive(channel_drive)
  );

  host_model host_model_i (
    .mclk(mclk), .busy(busy), .read_valid(read_valid), .read_data(read_data),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .burst_valid(burst_valid),
    .burst_byte(burst_byte), .frame_start(frame_start)
  );

  // 20 MHz clock
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a wait that ran out ends the run
  task automatic guard(input bit good);
    if (!good) begin
      err_count++;
      $display("mismatch handshake expected done seen timeout");
      final_report();
    end
  endtask

  task automatic wr(input logic [15:0] w);
    host_model_i.send(w, ok);
    guard(ok);
  endtask

  task automatic rdchk(input string what, input logic [15:0] w, input logic [7:0] exp);
    host_model_i.rd(w, d, ok);
    guard(ok);
    chk(what, {1'b0, exp}, {1'b0, d});
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl);
    n = 0;
    while (busy !== lvl && n < 700) begin
      @(negedge mclk);
      n++;
    end
    guard(n < 700);
  endtask

  initial begin
    rstn = 1'b0;
    independent_mode_pin = 1'b0;
    reset_pin_n = 1'b1;
    err_count = 0;
    n_checks = 0;
    // reset values while reset is held
    cyc(8);
    chk("busy in reset", 9'h001, {8'h00, busy});
    chk("control reset", 9'h003, {5'h00, control_bits});
    chk("read_valid in reset", 9'h000, {8'h00, read_valid});
    rstn = 1'b1;
    n = 0;
    while (busy !== 1'b0 && n < 700) begin
      @(negedge mclk);
      n++;
    end
    chk("reload length", 9'h001, {8'h00, (n >= 599 && n <= 601)});
    $display("test reset done");
    // table of single commands, each followed by a readback
    for (int i = 0; i < $size(rows); i++) begin
      wr(rows[i].cmd);
      rdchk("readback", rows[i].rq, rows[i].exp);
    end
    $display("test command table done");
    // tap decode in both modes
    wr(16'h1040);
    cyc(2);
    chk("lower taps", 9'h040, channel_drive[0].lower_string_resistance);
    chk("upper taps pot", 9'h0C0, channel_drive[0].upper_string_resistance);
    independent_mode_pin = 1'b1;
    wr(16'h1425);
    cyc(4);
    chk("upper taps pin", 9'h025, channel_drive[0].upper_string_resistance);
    independent_mode_pin = 1'b0;
    cyc(4);
    chk("upper taps back", 9'h0C0, channel_drive[0].upper_string_resistance);
    wr(16'hD007);
    cyc(3);
    chk("upper taps ctrl", 9'h025, channel_drive[0].upper_string_resistance);
    wr(16'hD003);
    $display("test string modes done");
    // end positions leave the stored code alone
    wr(16'h10FF);
    wr(16'h9081);
    cyc(2);
    chk("top upper", 9'h000, channel_drive[0].upper_string_resistance);
    chk("top lower", 9'h100, channel_drive[0].lower_string_resistance);
    rdchk("top wiper", 16'h3003, 8'hFF);
    wr(16'h9080);
    cyc(2);
    chk("top exit", 9'h001, channel_drive[0].upper_string_resistance);
    wr(16'h9001);
    cyc(2);
    chk("bottom lower", 9'h000, channel_drive[0].lower_string_resistance);
    wr(16'h9000);
    $display("test end positions done");
    // shutdown opens the upper string in potentiometer mode
    wr(16'hC001);
    cyc(2);
    chk("shutdown open", 9'h001, {8'h00, channel_drive[0].upper_open});
    chk("shutdown lower", 9'h000, {8'h00, channel_drive[0].lower_open});
    wr(16'hC000);
    cyc(2);
    chk("shutdown exit", 9'h000, {8'h00, channel_drive[0].upper_open});
    // linear mode shutdown of all channels opens both strings
    wr(16'hD007);
    wr(16'hC801);
    cyc(2);
    chk("shutdown upper ch2", 9'h001, {8'h00, channel_drive[1].upper_open});
    chk("shutdown lower ch2", 9'h001, {8'h00, channel_drive[1].lower_open});
    wr(16'hC800);
    wr(16'hD003);
    $display("test shutdown done");
    // burst bytes reuse the last command until a new start
    wr(16'h1000);
    host_model_i.burst(8'h33);
    rdchk("burst disabled", 16'h3003, 8'h00);
    wr(16'hD00B);
    cyc(2);
    chk("control burst", 9'h00B, {5'h00, control_bits});
    wr(16'h1000);
    host_model_i.burst(8'h0F);
    cyc(1);
    host_model_i.burst(8'h10);
    host_model_i.frame();
    rdchk("burst byte", 16'h3003, 8'h10);
    wr(16'h1010);
    host_model_i.frame();
    host_model_i.burst(8'h33);
    rdchk("disarmed burst", 16'h3003, 8'h10);
    host_model_i.frame();
    wr(16'h1000);
    host_model_i.burst(8'h20);
    host_model_i.frame();
    rdchk("burst after start", 16'h3003, 8'h20);
    wr(16'hD003);
    $display("test burst done");
    // software reset and reset pin reload from nonvolatile copies
    wr(16'h1044);
    wr(16'hB000);
    rdchk("soft reset", 16'h3003, 8'h7F);
    wr(16'h1055);
    reset_pin_n = 1'b0;
    cyc(3);
    reset_pin_n = 1'b1;
    wait_busy(1'b1);
    wait_busy(1'b0);
    rdchk("pin reset ch1", 16'h3003, 8'h7F);
    rdchk("pin reset ch2", 16'h3103, 8'h22);
    $display("test reload done");
    final_report();
  end
endmodule // dual_digipot_command_decoder_tb
